// ### core/trm_regs.sv
// result, soft reset, lock and alarm status registers with the limit comparators
// assumes a serial engine in front giving pointer/write/read strobes, a converter
// giving one-cycle done pulses, and limit/hysteresis words held elsewhere
`timescale 1ns/1ps
`include "trm_cfg.svh"

// What this block does
// R1: 13-bit results; local 00h, remotes 01h-04h
// R2: low four result bits are sixteenths
// R3: results read-only, overwritten per conversion
// R4: reads anytime; zero before first conversion
// R5: bit15 at 20h soft-resets; reads zero
// R6: soft reset ignored while locked
// R7: level1 status at 21h, bits 11-7
// R8: level1 flag sets above level1 limit
// R9: level1 flag self-clears below limit-hysteresis
// R10: first pin low while any level1 flag
// R11: level2 status at 22h, same layout
// R12: level2 flag set/clear with shared hysteresis
// R13: second pin low while any level2 flag
// R14: release test includes equality
// R15: diode open status at 23h, bits 11-8
// R16: open flags never drive pins directly
// R17: C4h lock/unlock codes; reads 8000h locked
// R18: pointer set first; unassigned writes ignored
// R19: compare only at result update points
module trm_regs
    import trm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire trm_acc_t acc,
    input wire logic conv_done,
    input wire trm_conv_t conv,
    input wire logic [3:0] diode_open,
    input wire trm_limits_t [`TRM_NCH-1:0] limits,
    input wire logic [15:0] hyst_word,
    output logic [15:0] rdata_q,
    output logic rd_valid_q,
    output logic sw_reset_q,
    output logic lock_q,
    output logic first_alarm_pin_n_q,
    output logic first_alarm_oe_q,
    output logic second_alarm_pin_n_q,
    output logic second_alarm_oe_q
);

    // ------------------------------------------------------------
    // pointer and access decode
    // ------------------------------------------------------------
    logic [7:0] ptr_q;
    logic [7:0] eff_ptr;
    logic srst_hit;
    logic lock_hit;

    // a write that carries a pointer uses it at once
    assign eff_ptr = acc.ptr_set ? acc.ptr : ptr_q;
    // writes landing in the soft reset cycle are lost, so the reset stays a single pulse
    assign srst_hit = acc.wr && eff_ptr == `TRM_PTR_SRST && acc.wdata[`TRM_SRST_BIT] && !sw_reset_q;
    assign lock_hit = acc.wr && eff_ptr == `TRM_PTR_LOCK && !sw_reset_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ptr_q <= `TRM_PTR_POR;
        end
        else if (sw_reset_q)
        begin
            ptr_q <= `TRM_PTR_POR;
        end
        else if (acc.ptr_set)
        begin
            ptr_q <= acc.ptr; // R18
        end
    end

    // ------------------------------------------------------------
    // lock and software reset
    // ------------------------------------------------------------
    // lock is kept across a soft reset, else an unlocked reset would relock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lock_q <= `TRM_LOCK_POR;
        end
        else if (lock_hit)
        begin
            if (acc.wdata == `TRM_LOCK_CODE)
            begin
                lock_q <= 1'b1; // R17
            end
            else if (acc.wdata == `TRM_UNLOCK_CODE)
            begin
                lock_q <= 1'b0; // R17
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sw_reset_q <= 1'b0;
        end
        else
        begin
            sw_reset_q <= srst_hit && !lock_q; // R5 R6
        end
    end

    // ------------------------------------------------------------
    // per-channel results and comparators
    // ------------------------------------------------------------
    logic [12:0] res_all [`TRM_NCH];
    logic [`TRM_NCH-1:0] lvl1_q;
    logic [`TRM_NCH-1:0] lvl2_q;
    logic [`TRM_NCH-1:0] lvl1_d;
    logic [`TRM_NCH-1:0] lvl2_d;
    logic signed [14:0] hyst_ext;

    // hysteresis is a 13-bit magnitude; 15 bits keep the lowest limit minus it from wrapping
    assign hyst_ext = {2'b00, hyst_word[`TRM_RES_MSB:`TRM_RES_LSB]};

    for (genvar i = 0; i < `TRM_NCH; i++)
    begin : g_ch
        logic upd;
        logic [12:0] res_q;
        logic signed [14:0] t_new;
        logic signed [14:0] lim1;
        logic signed [14:0] lim2;
        logic over1;
        logic over2;
        logic below1;
        logic below2;

        assign upd = conv_done && conv.chan == 3'(i);
        assign t_new = {{2{conv.value[12]}}, conv.value};
        assign lim1 = {{2{limits[i].level1[`TRM_RES_MSB]}}, limits[i].level1[`TRM_RES_MSB:`TRM_RES_LSB]};
        assign lim2 = {{2{limits[i].level2[`TRM_RES_MSB]}}, limits[i].level2[`TRM_RES_MSB:`TRM_RES_LSB]};
        assign over1 = t_new > lim1; // R8
        assign over2 = t_new > lim2; // R12
        assign below1 = t_new <= lim1 - hyst_ext; // R9 R14
        assign below2 = t_new <= lim2 - hyst_ext; // R12 R14

        // between the two thresholds a flag keeps its last state
        always_comb
        begin
            lvl1_d[i] = lvl1_q[i];
            lvl2_d[i] = lvl2_q[i];
            if (upd)
            begin
                if (over1)
                begin
                    lvl1_d[i] = 1'b1; // R8 R19
                end
                else if (below1)
                begin
                    lvl1_d[i] = 1'b0; // R9 R19
                end
                if (over2)
                begin
                    lvl2_d[i] = 1'b1; // R12 R19
                end
                else if (below2)
                begin
                    lvl2_d[i] = 1'b0; // R12 R19
                end
            end
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                res_q <= `TRM_RES_ZERO; // R4
            end
            else if (sw_reset_q)
            begin
                res_q <= `TRM_RES_ZERO; // R4 R5
            end
            else if (upd)
            begin
                res_q <= conv.value; // R1 R3
            end
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                lvl1_q[i] <= 1'b0;
                lvl2_q[i] <= 1'b0;
            end
            else if (sw_reset_q)
            begin
                lvl1_q[i] <= 1'b0;
                lvl2_q[i] <= 1'b0;
            end
            else
            begin
                lvl1_q[i] <= lvl1_d[i];
                lvl2_q[i] <= lvl2_d[i];
            end
        end

        assign res_all[i] = res_q;
    end

    // ------------------------------------------------------------
    // diode open status
    // ------------------------------------------------------------
    logic [3:0] open_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            open_q <= 4'h0;
        end
        else if (sw_reset_q)
        begin
            open_q <= 4'h0;
        end
        else
        begin
            open_q <= diode_open; // R15
        end
    end

    // ------------------------------------------------------------
    // alarm pins
    // ------------------------------------------------------------
    // pins follow the flag next values so they move in the same cycle as the flags;
    // open flags are deliberately not in these terms
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            first_alarm_pin_n_q <= 1'b1;
            first_alarm_oe_q <= 1'b0;
            second_alarm_pin_n_q <= 1'b1;
            second_alarm_oe_q <= 1'b0;
        end
        else if (sw_reset_q)
        begin
            first_alarm_pin_n_q <= 1'b1;
            first_alarm_oe_q <= 1'b0;
            second_alarm_pin_n_q <= 1'b1;
            second_alarm_oe_q <= 1'b0;
        end
        else
        begin
            first_alarm_pin_n_q <= ~|lvl1_d; // R10 R16
            first_alarm_oe_q <= |lvl1_d; // R10
            second_alarm_pin_n_q <= ~|lvl2_d; // R13 R16
            second_alarm_oe_q <= |lvl2_d; // R13
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0] rd_word;

    always_comb
    begin
        rd_word = `TRM_WORD_ZERO;
        if (eff_ptr <= `TRM_PTR_REM4)
        begin
            rd_word = {res_all[eff_ptr[2:0]], 3'h0}; // R1 R2
        end
        else
        begin
            case (eff_ptr)
                `TRM_PTR_SRST: rd_word = `TRM_WORD_ZERO; // R5
                `TRM_PTR_ST1: rd_word = 16'(lvl1_q) << `TRM_FLAG_LSB; // R7
                `TRM_PTR_ST2: rd_word = 16'(lvl2_q) << `TRM_FLAG_LSB; // R11
                `TRM_PTR_OPEN: rd_word = 16'(open_q) << `TRM_OPEN_LSB; // R15
                `TRM_PTR_LOCK: rd_word = lock_q ? `TRM_LOCK_RD : `TRM_WORD_ZERO; // R17
                default: rd_word = `TRM_WORD_ZERO; // R18
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= `TRM_WORD_ZERO;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= acc.rd; // R4
            if (acc.rd)
            begin
                rdata_q <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_lock_wr;
        lock_hit && acc.wdata == `TRM_LOCK_CODE;
    endsequence

    sequence s_rd_lock;
        acc.rd && eff_ptr == `TRM_PTR_LOCK && !lock_hit;
    endsequence

    sequence s_upd0_hot;
        conv_done && conv.chan == 3'h0 && !sw_reset_q
            && $signed({conv.value[12], conv.value}) > g_ch[0].lim1;
    endsequence

    sequence s_upd0_cool;
        conv_done && conv.chan == 3'h0 && !sw_reset_q && g_ch[0].below1;
    endsequence

    result_update_a: assert property (conv_done && conv.chan == 3'h1 && !sw_reset_q |=> // R3
        res_all[1] == $past(conv.value))
        else $error("result not loaded from conversion");
    result_hold_a: assert property (!(conv_done && conv.chan == 3'h2) && !sw_reset_q |=> // R3
        $stable(res_all[2]))
        else $error("result changed without conversion");
    reset_zero_a: assert property (sw_reset_q |=> res_all[0] == `TRM_RES_ZERO // R4
        && lvl1_q == 5'h00 && first_alarm_pin_n_q)
        else $error("soft reset did not clear state");
    srst_fire_a: assert property (srst_hit && !lock_q |=> sw_reset_q ##1 !sw_reset_q) // R5
        else $error("soft reset not a single pulse");
    lock_ignore_a: assert property (srst_hit && lock_q |=> !sw_reset_q) // R6
        else $error("soft reset taken while locked");
    lvl1_set_a: assert property (s_upd0_hot |=> lvl1_q[0] && !first_alarm_pin_n_q) // R8
        else $error("level1 flag or pin missed overtemperature");
    lvl1_clr_a: assert property (s_upd0_cool |=> !lvl1_q[0]) // R9
        else $error("level1 flag did not release");
    pin1_track_a: assert property (##1 first_alarm_pin_n_q == ~|lvl1_q // R10
        && first_alarm_oe_q == |lvl1_q)
        else $error("first pin disagrees with flags");
    pin2_track_a: assert property (##1 second_alarm_pin_n_q == ~|lvl2_q) // R13
        else $error("second pin disagrees with flags");
    flag_quiet_a: assert property (!conv_done && !sw_reset_q |=> $stable(lvl1_q) // R19
        && $stable(lvl2_q))
        else $error("flags moved without an update");
    open_read_a: assert property (acc.rd && eff_ptr == `TRM_PTR_OPEN |=> // R15
        rdata_q == {4'h0, $past(open_q), 8'h00})
        else $error("open status layout wrong");
    st1_read_a: assert property (acc.rd && eff_ptr == `TRM_PTR_ST1 |=> // R7
        rdata_q[15:12] == 4'h0 && rdata_q[6:0] == 7'h00 && rdata_q[11:7] == $past(lvl1_q))
        else $error("level1 status layout wrong");
    // the host leaves one idle cycle between a write and the next read
    lock_read_a: assert property (s_lock_wr ##1 !lock_hit ##1 s_rd_lock |=> rdata_q == `TRM_LOCK_RD) // R17
        else $error("lock readback wrong");
    undef_read_a: assert property (acc.rd && eff_ptr > `TRM_PTR_REM4 && eff_ptr < `TRM_PTR_SRST |=> // R18
        rd_valid_q && rdata_q == `TRM_WORD_ZERO)
        else $error("unassigned read not answered");

endmodule : trm_regs

// ### common/trm_cfg.svh
// named pointers, codes, field positions and reset values of the result/alarm register set
// assumes inclusion by bare name from the package and the design
`ifndef TRM_CFG_SVH
`define TRM_CFG_SVH
`define TRM_NCH 5
`define TRM_PTR_POR 8'h00
`define TRM_PTR_LOCAL 8'h00
`define TRM_PTR_REM4 8'h04
`define TRM_PTR_SRST 8'h20
`define TRM_PTR_ST1 8'h21
`define TRM_PTR_ST2 8'h22
`define TRM_PTR_OPEN 8'h23
`define TRM_PTR_LOCK 8'hc4
`define TRM_LOCK_CODE 16'h5ca6
`define TRM_UNLOCK_CODE 16'heb19
`define TRM_LOCK_RD 16'h8000
`define TRM_LOCK_POR 1'b1
`define TRM_WORD_ZERO 16'h0000
`define TRM_RES_ZERO 13'h0000
`define TRM_SRST_BIT 15
`define TRM_RES_MSB 15
`define TRM_RES_LSB 3
`define TRM_FLAG_LSB 7
`define TRM_OPEN_LSB 8
`endif

// ### common/trm_pkg.sv
// types shared by the result/alarm register set and its neighbours
// assumes the cfg header is on the include path
`include "trm_cfg.svh"
package trm_pkg;
    // 13-bit two's complement reading, lsb = 1/16 degree
    typedef logic signed [12:0] trm_temp_t;
    typedef struct packed {
        logic [2:0] chan;
        trm_temp_t value;
    } trm_conv_t;
    typedef struct packed {
        logic [15:0] level1;
        logic [15:0] level2;
    } trm_limits_t;
    typedef struct packed {
        logic ptr_set;
        logic wr;
        logic rd;
        logic [7:0] ptr;
        logic [15:0] wdata;
    } trm_acc_t;
endpackage : trm_pkg

// ### testbench/trm_host_model.sv
// host controller model driving the parallel register strobes
// assumes one clock; requests change at the falling edge
`timescale 1ns/1ps
module trm_host_model
    import trm_pkg::*;
(
    input wire logic clock,
    output trm_acc_t acc,
    input wire logic rd_valid_q,
    input wire logic [15:0] rdata_q
);
    initial acc = '0;

    // pointer is loaded with every access, never left stale
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(negedge clock);
        acc = '{ptr_set: 1'b1, wr: 1'b1, rd: 1'b0, ptr: p, wdata: d};
        @(negedge clock);
        // idle fields show the inverse so stale data never looks valid
        acc = '{ptr_set: 1'b0, wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic ok);
        @(negedge clock);
        acc = '{ptr_set: 1'b1, wr: 1'b0, rd: 1'b1, ptr: p, wdata: 16'h0000};
        @(negedge clock);
        acc = '{ptr_set: 1'b0, wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: 16'hffff};
        ok = 1'b0;
        d = 16'hxxxx;
        for (int i = 0; i < 3 && !ok; i++)
        begin
            if (rd_valid_q === 1'b1)
            begin
                ok = 1'b1;
                d = rdata_q;
            end
            else
                @(negedge clock);
        end
    endtask : rd
endmodule : trm_host_model

// ### testbench/testbench.sv
// self-checking bench for the result, status and alarm register set
// assumes the host model drives the register strobes
`timescale 1ns/1ps
`include "trm_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
    import trm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    trm_acc_t acc;
    logic conv_done = 1'b0;
    trm_conv_t conv = '0;
    logic [3:0] diode_open = 4'h0;
    trm_limits_t [`TRM_NCH-1:0] limits = '0;
    logic [15:0] hyst_word = 16'h0000;
    logic [15:0] rdata_q;
    logic rd_valid_q, sw_reset_q, lock_q, p1_n, oe1, p2_n, oe2;
    int errors = 0, check_count = 0, srst_cnt = 0, hy, ch, v;
    int lim1[5], lim2[5];
    logic [4:0] f1 = 5'h00, f2 = 5'h00;
    logic [12:0] res[5];
    logic [15:0] d;
    logic ok;

    trm_regs u_dut (.clock(clock), .rst(rst), .acc(acc), .conv_done(conv_done), .conv(conv),
        .diode_open(diode_open), .limits(limits), .hyst_word(hyst_word), .rdata_q(rdata_q),
        .rd_valid_q(rd_valid_q), .sw_reset_q(sw_reset_q), .lock_q(lock_q), .first_alarm_pin_n_q(p1_n),
        .first_alarm_oe_q(oe1), .second_alarm_pin_n_q(p2_n), .second_alarm_oe_q(oe2));
    trm_host_model u_host (.clock(clock), .acc(acc), .rd_valid_q(rd_valid_q), .rdata_q(rdata_q));

    always #12.5 clock = ~clock;
    always @(posedge clock) if (sw_reset_q === 1'b1) srst_cnt++;

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic upd(logic cur, int val, int lim, int h);
        if (val > lim) return 1'b1;
        if (val <= lim - h) return 1'b0;
        return cur;
    endfunction : upd

    function automatic logic [15:0] st(logic [4:0] f);
        return {4'h0, f[4:1], f[0], 7'h00};
    endfunction : st

    task automatic chk_rd(logic [7:0] p, logic [15:0] e);
        u_host.rd(p, d, ok);
        `CHK("rd_valid", 1'b1, ok)
        `CHK("rdata", e, d)
    endtask : chk_rd

    task automatic chk_pins();
        `CHK("pin1", ~|f1, p1_n)
        `CHK("oe1", |f1, oe1)
        `CHK("pin2", ~|f2, p2_n)
        `CHK("oe2", |f2, oe2)
    endtask : chk_pins

    task automatic chk_all();
        for (int c = 0; c < 5; c++)
            chk_rd(8'(c), {res[c], 3'b000});
        chk_rd(`TRM_PTR_ST1, st(f1));
        chk_rd(`TRM_PTR_ST2, st(f2));
        chk_pins();
    endtask : chk_all

    task automatic do_conv(int c, int val);
        @(negedge clock);
        conv_done = 1'b1;
        conv.chan = 3'(c);
        conv.value = 13'(val);
        @(negedge clock);
        conv_done = 1'b0;
        conv.value = ~conv.value;
        if (c < 5)
        begin
            res[c] = 13'(val);
            f1[c] = upd(f1[c], val, lim1[c], hy);
            f2[c] = upd(f2[c], val, lim2[c], hy);
        end
        @(negedge clock);
        chk_pins();
    endtask : do_conv

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(34));
        hy = $urandom % 64;
        hyst_word = {13'(hy), 3'b000};
        for (int c = 0; c < 5; c++)
        begin
            lim1[c] = $urandom % 1600;
            lim2[c] = lim1[c] + 16 + $urandom % 400;
            limits[c] = {13'(lim1[c]), 3'b000, 13'(lim2[c]), 3'b000};
            res[c] = 13'h0000;
        end
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        chk_all();
        chk_rd(`TRM_PTR_LOCK, 16'h8000);
        chk_rd(`TRM_PTR_SRST, 16'h0000);
        chk_rd(8'h10, 16'h0000);
        // release exactly at limit minus hysteresis, hold at the limit itself
        do_conv(0, lim1[0] + 1);
        do_conv(0, lim1[0]);
        do_conv(0, lim1[0] - hy);
        do_conv(7, 100);
        chk_all();
        u_host.wr(8'h00, 16'h1234);
        u_host.wr(`TRM_PTR_ST1, 16'hffff);
        u_host.wr(`TRM_PTR_SRST, 16'h8000);
        repeat (3) @(negedge clock);
        `CHK("srst_locked", 0, srst_cnt)
        chk_all();
        repeat (60)
        begin
            ch = $urandom % 5;
            v = (($urandom % 2) ? lim2[ch] : lim1[ch]) + int'($urandom % 97) - 48;
            do_conv(ch, v);
            chk_all();
        end
        // open flags show in their register only, never on the pins
        for (int i = 0; i < 4; i++)
        begin
            diode_open = 4'(1 << i) | 4'($urandom);
            repeat (2) @(negedge clock);
            chk_rd(`TRM_PTR_OPEN, {4'h0, diode_open, 8'h00});
            chk_pins();
        end
        diode_open = 4'h0;
        u_host.wr(`TRM_PTR_LOCK, 16'h1234);
        chk_rd(`TRM_PTR_LOCK, 16'h8000);
        u_host.wr(`TRM_PTR_LOCK, 16'heb19);
        chk_rd(`TRM_PTR_LOCK, 16'h0000);
        `CHK("lock", 1'b0, lock_q)
        u_host.wr(`TRM_PTR_SRST, 16'h7fff);
        repeat (3) @(negedge clock);
        `CHK("srst_zero", 0, srst_cnt)
        u_host.wr(`TRM_PTR_SRST, 16'h8000);
        repeat (3) @(negedge clock);
        `CHK("srst", 1, srst_cnt)
        f1 = 5'h00;
        f2 = 5'h00;
        for (int c = 0; c < 5; c++)
            res[c] = 13'h0000;
        chk_all();
        chk_rd(`TRM_PTR_LOCK, 16'h0000);
        u_host.wr(`TRM_PTR_LOCK, 16'h5ca6);
        chk_rd(`TRM_PTR_LOCK, 16'h8000);
        end_of_test();
    end

    initial
    begin
        #500000;
        errors++;
        end_of_test();
    end
endmodule : testbench
